// ### design/tsiwp_top.sv
// tsiwp_top: write-mode serial programming port of a tuner synthesizer.
// assumes bus pins and strap pins are asynchronous; auto band inputs
// come from logic on i_mclk. read mode and the analog loop are outside.
`timescale 1ns/1ps
module tsiwp_top (
	input wire logic i_mclk,              // system clock, 10 MHz
	input wire logic i_reset,             // synchronous reset, high
	input wire logic i_ce,                // clock enable, freezes all
	input wire logic i_scl,               // bus clock pin
	input wire logic i_sda,               // bus data pin level
	output logic o_sda_out,               // data pin drive value
	output logic o_sda_oe_n,              // data pin enable, low drives
	input wire logic [1:0] i_addr_strap_pin, // sensed address strap
	input wire logic [2:0] i_auto_ports,  // auto band ports 3..1
	input wire logic [2:0] i_auto_pump_sel, // auto pump current
	output logic [14:0] o_ratio,          // main division ratio
	output logic o_calc_start,            // pulse: calculation begins
	output logic o_calc_busy,             // calculation period running
	output logic o_ratio_valid,           // result stands undisturbed
	output logic [2:0] o_ref_ratio_sel,   // reference ratio select
	output logic [2:0] o_test_code,       // stored test code
	output logic o_gain_time_const,       // 1 fast, 0 slow
	output logic [2:0] o_takeover_level,  // gain take-over level
	output logic [2:0] o_pump_current_sel, // effective pump current
	output logic [4:0] o_port_drive,      // effective ports 5..1
	output logic [2:0] o_band_sel,        // bands high, mid, low
	output logic [1:0] o_crystal_buffer_out_sel,       // crystal buffer source
	output logic [1:0] o_pump_mode,       // charge pump mode
	output logic o_tuning_volt_en,        // tuning voltage enabled
	output logic o_auto_loop_bandwidth    // auto bandwidth active
);

	tsiwp_pkg::tsiwp_state_e state;
	logic sda, scl_rise, scl_fall, start_cond, stop_cond;
	logic [1:0] strap_s1, strap_s2;
	logic [7:0] shreg;
	logic [3:0] bit_cnt;
	logic is_addr;
	logic addressed;
	logic first_data;
	logic [2:0] byte_idx;
	logic [6:0] pend_upper;
	logic [7:0] pend_lower;
	logic got_upper, got_lower;
	logic [2:0] pump_sel;
	logic [4:0] port_drive;
	logic auto_loop_bandwidth;
	logic [8:0] calc_cnt;
	logic calc_dirty;
	logic byte_done, data_done, addr_hit;
	logic [2:0] cur_idx;

	// crystal buffer source for each test code
	function automatic logic [1:0] crystal_buffer_out_decode(input logic [2:0] code);
		unique case (code)
			tsiwp_pkg::TEST_XTAL_OFF: crystal_buffer_out_decode = tsiwp_pkg::XT_OFF;
			tsiwp_pkg::TEST_XTAL_ON: crystal_buffer_out_decode = tsiwp_pkg::XT_XTAL;
			tsiwp_pkg::TEST_HALF_DIV_PUMP_OFF:
				crystal_buffer_out_decode = tsiwp_pkg::XT_HALF_DIV;
			tsiwp_pkg::TEST_AUTO_LOOP_BANDWIDTH_TOGGLE: crystal_buffer_out_decode = tsiwp_pkg::XT_XTAL;
			tsiwp_pkg::TEST_COMP: crystal_buffer_out_decode = tsiwp_pkg::XT_COMP;
			tsiwp_pkg::TEST_HALF_DIV: crystal_buffer_out_decode = tsiwp_pkg::XT_HALF_DIV;
			tsiwp_pkg::TEST_PUMP_SINK: crystal_buffer_out_decode = tsiwp_pkg::XT_XTAL;
			tsiwp_pkg::TEST_PUMP_SOURCE: crystal_buffer_out_decode = tsiwp_pkg::XT_OFF;
		endcase
	endfunction

	// charge pump mode for each test code
	function automatic logic [1:0] pump_decode(input logic [2:0] code);
		unique case (code)
			tsiwp_pkg::TEST_HALF_DIV_PUMP_OFF:
				pump_decode = tsiwp_pkg::PUMP_OFF;
			tsiwp_pkg::TEST_PUMP_SINK: pump_decode = tsiwp_pkg::PUMP_SINK;
			tsiwp_pkg::TEST_PUMP_SOURCE:
				pump_decode = tsiwp_pkg::PUMP_SOURCE;
			default: pump_decode = tsiwp_pkg::PUMP_NORMAL;
		endcase
	endfunction

	// band enables from ports one and two
	function automatic logic [2:0] band_decode(input logic [1:0] p);
		band_decode = {~p[1] & ~p[0], p[1], p[0]};
	endfunction

	tsiwp_line_cond u_line (
		.i_mclk(i_mclk),
		.i_reset(i_reset),
		.i_ce(i_ce),
		.i_scl(i_scl),
		.i_sda(i_sda),
		.o_sda(sda),
		.o_scl_rise(scl_rise),
		.o_scl_fall(scl_fall),
		.o_start(start_cond),
		.o_stop(stop_cond)
	);

	// strap pins may move at any time, so two flops before use
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			strap_s1 <= 2'h0;
			strap_s2 <= 2'h0;
		end else if (i_ce) begin
			strap_s1 <= i_addr_strap_pin;
			strap_s2 <= strap_s1;
		end
	end

	// byte boundaries and address match
	assign byte_done = (state == tsiwp_pkg::ST_RECV) && scl_fall &&
		(bit_cnt == tsiwp_pkg::BITS_PER_BYTE);
	assign addr_hit = (shreg[7:3] == tsiwp_pkg::ADDR_FIXED) &&
		(shreg[2:1] == strap_s2) &&
		(shreg[0] == tsiwp_pkg::WRITE_BIT);
	assign data_done = byte_done && !is_addr;
	// the first data byte names itself by its top bit
	assign cur_idx = first_data ?
		(shreg[tsiwp_pkg::KIND_BIT] ? tsiwp_pkg::IDX_CTRL_ONE :
		tsiwp_pkg::IDX_DIV_UPPER) : byte_idx;

	// receiver: shifts bits in, acknowledges, skips foreign transfers
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			state <= tsiwp_pkg::ST_IDLE;
			bit_cnt <= 4'h0;
			shreg <= 8'h00;
			is_addr <= 1'b0;
		end else if (i_ce) begin
			if (start_cond) begin
				state <= tsiwp_pkg::ST_RECV;
				bit_cnt <= 4'h0;
				is_addr <= 1'b1;
			end else if (stop_cond) begin
				state <= tsiwp_pkg::ST_IDLE;
			end else begin
				unique case (state)
					tsiwp_pkg::ST_IDLE: begin
						bit_cnt <= 4'h0;
					end
					tsiwp_pkg::ST_RECV: begin
						if (scl_rise && bit_cnt != tsiwp_pkg::BITS_PER_BYTE) begin
							shreg <= {shreg[6:0], sda};
							bit_cnt <= bit_cnt + 4'h1;
						end
						if (byte_done) begin
							if (is_addr && !addr_hit)
								state <= tsiwp_pkg::ST_SKIP;
							else
								state <= tsiwp_pkg::ST_ACK;
							is_addr <= 1'b0;
						end
					end
					tsiwp_pkg::ST_ACK: begin
						// more bytes follow without re-addressing
						if (scl_fall) begin
							state <= tsiwp_pkg::ST_RECV;
							bit_cnt <= 4'h0;
						end
					end
					tsiwp_pkg::ST_SKIP: begin
						bit_cnt <= 4'h0;
					end
				endcase
			end
		end
	end

	// data pin: pulled low for the acknowledge slot only, released on
	// the following clock fall so the controller regains the line
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			o_sda_out <= 1'b0;
			o_sda_oe_n <= 1'b1;
		end else if (i_ce) begin
			o_sda_out <= 1'b0;
			if (start_cond || stop_cond)
				o_sda_oe_n <= 1'b1;
			else if (byte_done && (!is_addr || addr_hit))
				o_sda_oe_n <= 1'b0;
			else if (state == tsiwp_pkg::ST_ACK && scl_fall)
				o_sda_oe_n <= 1'b1;
		end
	end

	// transfer tracking: byte index and which divider bytes arrived
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			addressed <= 1'b0;
			first_data <= 1'b1;
			byte_idx <= tsiwp_pkg::IDX_DIV_UPPER;
			got_upper <= 1'b0;
			got_lower <= 1'b0;
		end else if (i_ce) begin
			if (start_cond) begin
				addressed <= 1'b0;
				first_data <= 1'b1;
				byte_idx <= tsiwp_pkg::IDX_DIV_UPPER;
				got_upper <= 1'b0;
				got_lower <= 1'b0;
			end else if (stop_cond) begin
				addressed <= 1'b0;
			end else if (byte_done && is_addr && addr_hit) begin
				addressed <= 1'b1;
			end else if (data_done) begin
				first_data <= 1'b0;
				// saturate so surplus bytes land in the dead slot
				if (cur_idx != tsiwp_pkg::IDX_DONE)
					byte_idx <= cur_idx + 3'h1;
				if (cur_idx == tsiwp_pkg::IDX_DIV_UPPER)
					got_upper <= 1'b1;
				if (cur_idx == tsiwp_pkg::IDX_DIV_LOWER)
					got_lower <= 1'b1;
			end
		end
	end

	// divider bytes are held aside until the transfer stops
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			pend_upper <= 7'h00;
			pend_lower <= 8'h00;
		end else if (i_ce && data_done) begin
			if (cur_idx == tsiwp_pkg::IDX_DIV_UPPER)
				pend_upper <= shreg[6:0];
			if (cur_idx == tsiwp_pkg::IDX_DIV_LOWER)
				pend_lower <= shreg;
		end
	end

	// ratio is applied at stop, and only when both halves came in the
	// same transfer; a lone half would produce a mixed ratio
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			o_ratio <= tsiwp_pkg::RST_RATIO;
		end else if (i_ce && stop_cond && addressed) begin
			if (got_upper && got_lower)
				o_ratio <= {pend_upper, pend_lower};
		end
	end

	// control one: applied on the byte's eighth clock, no stop needed
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			o_test_code <= tsiwp_pkg::RST_TEST_CODE;
			o_ref_ratio_sel <= tsiwp_pkg::RST_REF_SEL;
			o_gain_time_const <= tsiwp_pkg::RST_GAIN_TC;
			o_takeover_level <= tsiwp_pkg::RST_TAKEOVER;
			auto_loop_bandwidth <= tsiwp_pkg::RST_AUTO_LOOP_BANDWIDTH;
		end else if (i_ce && data_done &&
			cur_idx == tsiwp_pkg::IDX_CTRL_ONE) begin
			if (shreg[tsiwp_pkg::CTRL_SEL_BIT]) begin
				o_test_code <=
					shreg[tsiwp_pkg::TEST_MSB:tsiwp_pkg::TEST_LSB];
				o_ref_ratio_sel <= shreg[tsiwp_pkg::REF_MSB:0];
				// every write of the toggle code flips the feature
				if (shreg[tsiwp_pkg::TEST_MSB:tsiwp_pkg::TEST_LSB] ==
					tsiwp_pkg::TEST_AUTO_LOOP_BANDWIDTH_TOGGLE)
					auto_loop_bandwidth <= ~auto_loop_bandwidth;
			end else begin
				o_gain_time_const <= shreg[tsiwp_pkg::GAIN_TC_BIT];
				o_takeover_level <= shreg[tsiwp_pkg::TAKEOVER_MSB:0];
			end
		end
	end

	// control two: pump current and port drive, also on eighth clock
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			pump_sel <= tsiwp_pkg::RST_PUMP_SEL;
			port_drive <= tsiwp_pkg::RST_PORT_DRIVE;
		end else if (i_ce && data_done &&
			cur_idx == tsiwp_pkg::IDX_CTRL_TWO) begin
			pump_sel <= shreg[tsiwp_pkg::PUMP_MSB:tsiwp_pkg::PUMP_LSB];
			port_drive <= shreg[tsiwp_pkg::PORTS_MSB:0];
		end
	end

	// calculation period: a start inside it spoils the result, and the
	// spoiled result stays invalid until the next calculation completes
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			calc_cnt <= 9'h000;
			calc_dirty <= 1'b0;
			o_calc_start <= 1'b0;
			o_calc_busy <= 1'b0;
			o_ratio_valid <= 1'b0;
		end else if (i_ce) begin
			o_calc_start <= 1'b0;
			if (stop_cond && addressed) begin
				o_calc_start <= 1'b1;
				o_calc_busy <= 1'b1;
				o_ratio_valid <= 1'b0;
				calc_dirty <= 1'b0;
				calc_cnt <= tsiwp_pkg::CALC_CYCLES;
			end else if (o_calc_busy) begin
				if (start_cond)
					calc_dirty <= 1'b1;
				if (calc_cnt == 9'h001) begin
					o_calc_busy <= 1'b0;
					o_ratio_valid <= !(calc_dirty || start_cond);
				end
				calc_cnt <= calc_cnt - 9'h001;
			end
		end
	end

	// effective outputs: auto bandwidth overrides pump select and the
	// band ports; port five and four always follow their bits
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			o_pump_current_sel <= tsiwp_pkg::RST_PUMP_SEL;
			o_port_drive <= tsiwp_pkg::RST_PORT_DRIVE;
			o_band_sel <= band_decode(tsiwp_pkg::RST_PORT_DRIVE[1:0]);
			o_crystal_buffer_out_sel <= crystal_buffer_out_decode(tsiwp_pkg::RST_TEST_CODE);
			o_pump_mode <= pump_decode(tsiwp_pkg::RST_TEST_CODE);
			o_tuning_volt_en <= 1'b0;
			o_auto_loop_bandwidth <= tsiwp_pkg::RST_AUTO_LOOP_BANDWIDTH;
		end else if (i_ce) begin
			if (auto_loop_bandwidth) begin
				o_pump_current_sel <= i_auto_pump_sel;
				o_port_drive <= {port_drive[4:3], i_auto_ports};
				o_band_sel <= band_decode(i_auto_ports[1:0]);
			end else begin
				o_pump_current_sel <= pump_sel;
				o_port_drive <= port_drive;
				o_band_sel <= band_decode(port_drive[1:0]);
			end
			o_crystal_buffer_out_sel <= crystal_buffer_out_decode(o_test_code);
			o_pump_mode <= pump_decode(o_test_code);
			o_tuning_volt_en <=
				o_test_code != tsiwp_pkg::TEST_PUMP_SINK;
			o_auto_loop_bandwidth <= auto_loop_bandwidth;
		end
	end

endmodule // tsiwp_top

// ### design/tsiwp_pkg.sv
// tsiwp_pkg: constants, field positions, reset values and state codes
// for the tuner synthesizer write-mode serial programming port.
// assumes a single 10 MHz system clock shared by every design file.
package tsiwp_pkg;

	// device address: five fixed upper bits, two strap bits, then r/w
	localparam logic [4:0] ADDR_FIXED = 5'h18;
	localparam logic WRITE_BIT = 1'b0;

	// serial byte framing
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	// byte index inside one transfer, advanced after every data byte until IDX_DONE
	localparam logic [2:0] IDX_DIV_UPPER = 3'h0;
	localparam logic [2:0] IDX_DIV_LOWER = 3'h1;
	localparam logic [2:0] IDX_CTRL_ONE = 3'h2;
	localparam logic [2:0] IDX_CTRL_TWO = 3'h3;
	localparam logic [2:0] IDX_DONE = 3'h4;

	// field positions inside the data bytes
	localparam int KIND_BIT = 7;
	localparam int CTRL_SEL_BIT = 6;
	localparam int TEST_MSB = 5;
	localparam int TEST_LSB = 3;
	localparam int REF_MSB = 2;
	localparam int GAIN_TC_BIT = 3;
	localparam int TAKEOVER_MSB = 2;
	localparam int PUMP_MSB = 7;
	localparam int PUMP_LSB = 5;
	localparam int PORTS_MSB = 4;

	// test codes
	localparam logic [2:0] TEST_XTAL_OFF = 3'h0;
	localparam logic [2:0] TEST_XTAL_ON = 3'h1;
	localparam logic [2:0] TEST_HALF_DIV_PUMP_OFF = 3'h2;
	localparam logic [2:0] TEST_AUTO_LOOP_BANDWIDTH_TOGGLE = 3'h3;
	localparam logic [2:0] TEST_COMP = 3'h4;
	localparam logic [2:0] TEST_HALF_DIV = 3'h5;
	localparam logic [2:0] TEST_PUMP_SINK = 3'h6;
	localparam logic [2:0] TEST_PUMP_SOURCE = 3'h7;

	// crystal buffer output selection
	localparam logic [1:0] XT_OFF = 2'h0;
	localparam logic [1:0] XT_XTAL = 2'h1;
	localparam logic [1:0] XT_HALF_DIV = 2'h2;
	localparam logic [1:0] XT_COMP = 2'h3;

	// charge pump operating mode
	localparam logic [1:0] PUMP_NORMAL = 2'h0;
	localparam logic [1:0] PUMP_OFF = 2'h1;
	localparam logic [1:0] PUMP_SINK = 2'h2;
	localparam logic [1:0] PUMP_SOURCE = 2'h3;

	// values after reset
	localparam logic [2:0] RST_TEST_CODE = TEST_PUMP_SINK;
	localparam logic [2:0] RST_REF_SEL = 3'h0;
	localparam logic [14:0] RST_RATIO = 15'h0000;
	localparam logic RST_GAIN_TC = 1'b0;
	localparam logic [2:0] RST_TAKEOVER = 3'h0;
	localparam logic [2:0] RST_PUMP_SEL = 3'h0;
	localparam logic [4:0] RST_PORT_DRIVE = 5'h00;
	localparam logic RST_AUTO_LOOP_BANDWIDTH = 1'b0;

	// fractional calculation period after a stop
	localparam int CLK_PERIOD_NS = 100;
	localparam int CALC_TIME_US = 50;
	localparam logic [8:0] CALC_CYCLES =
		9'(CALC_TIME_US * 1000 / CLK_PERIOD_NS);

	// serial receiver states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RECV = 2'b01,
		ST_ACK = 2'b10,
		ST_SKIP = 2'b11
	} tsiwp_state_e;

endpackage

// ### design/tsiwp_line_cond.sv
// tsiwp_line_cond: synchronises the two bus lines into the system clock
// and reports clock edges and start/stop conditions as one-cycle pulses.
// assumes scl and sda come straight from pins, asynchronous to i_mclk.
`timescale 1ns/1ps
module tsiwp_line_cond (
	input wire logic i_mclk,       // system clock
	input wire logic i_reset,      // synchronous reset, active high
	input wire logic i_ce,         // clock enable
	input wire logic i_scl,        // bus clock pin level
	input wire logic i_sda,        // bus data pin level
	output logic o_sda,            // synchronised data level
	output logic o_scl_rise,       // pulse: bus clock rose
	output logic o_scl_fall,       // pulse: bus clock fell
	output logic o_start,          // pulse: start condition
	output logic o_stop            // pulse: stop condition
);

	logic scl_s1, scl_s2, scl_d;
	logic sda_s1, sda_s2, sda_d;

	// two-flop synchronisers, then one delay stage for edge detection;
	// lines idle high so reset to one avoids a false start
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			scl_s1 <= 1'b1;
			scl_s2 <= 1'b1;
			scl_d <= 1'b1;
			sda_s1 <= 1'b1;
			sda_s2 <= 1'b1;
			sda_d <= 1'b1;
		end else if (i_ce) begin
			scl_s1 <= i_scl;
			scl_s2 <= scl_s1;
			scl_d <= scl_s2;
			sda_s1 <= i_sda;
			sda_s2 <= sda_s1;
			sda_d <= sda_s2;
		end
	end

	// only the second and third stages are looked at
	assign o_sda = sda_s2;
	assign o_scl_rise = i_ce & scl_s2 & ~scl_d;
	assign o_scl_fall = i_ce & ~scl_s2 & scl_d;
	assign o_start = i_ce & scl_s2 & scl_d & sda_d & ~sda_s2;
	assign o_stop = i_ce & scl_s2 & scl_d & ~sda_d & sda_s2;

endmodule // tsiwp_line_cond

// ### tb/tsiwp_checker.sv
// tsiwp_checker: port-level assertions for the serial programming port.
// assumes it is bound to tsiwp_top and that the clock enable stays high
// while a calculation period runs.
`timescale 1ns/1ps
module tsiwp_checker (
	input wire logic i_mclk, // system clock
	input wire logic i_reset, // sync reset, high
	input wire logic i_scl, // bus clock pin
	input wire logic i_sda, // bus data pin
	input wire logic o_sda_oe_n, // data enable, low drives
	input wire logic [2:0] i_auto_ports, // auto band ports
	input wire logic [2:0] i_auto_pump_sel, // auto pump current
	input wire logic [14:0] o_ratio, // applied ratio
	input wire logic o_calc_start, // calculation pulse
	input wire logic o_calc_busy, // calculation period
	input wire logic o_ratio_valid, // result valid
	input wire logic [2:0] o_test_code, // stored test code
	input wire logic [2:0] o_pump_current_sel, // pump current
	input wire logic [4:0] o_port_drive, // ports 5..1
	input wire logic [2:0] o_band_sel, // high, mid, low
	input wire logic [1:0] o_crystal_buffer_out_sel, // buffer source
	input wire logic [1:0] o_pump_mode, // pump mode
	input wire logic o_tuning_volt_en, // tuning enable
	input wire logic o_auto_loop_bandwidth // auto bandwidth
);
	// per test code, code 7 in the top pair: buffer source, pump mode
	localparam logic [15:0] XT_TAB = 16'h1b64;
	localparam logic [15:0] PM_TAB = 16'he010;
	logic [2:0] code_d;
	logic [9:0] busy_len;

	// effective outputs follow the stored code one cycle late
	always_ff @(posedge i_mclk) begin
		code_d <= o_test_code;
	end

	// length of the running period; too long for a repetition operator
	always_ff @(posedge i_mclk) begin
		if (i_reset || !o_calc_busy) begin
			busy_len <= 10'h000;
		end else begin
			busy_len <= busy_len + 10'h001;
		end
	end

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_reset);

	property p_ack_edge; $changed(o_sda_oe_n) |-> !i_scl; endproperty
	a_ack_edge: assert property (p_ack_edge)
		else $error("ack edge while bus clock high");
	property p_ack_hold; $fell(o_sda_oe_n) |-> !o_sda_oe_n [*8]; endproperty
	a_ack_hold: assert property (p_ack_hold)
		else $error("ack released too early");
	property p_calc_stop; o_calc_start |-> i_scl && i_sda; endproperty
	a_calc_stop: assert property (p_calc_stop)
		else $error("calculation started away from a stop");
	property p_ratio_stop;
		$changed(o_ratio) |-> (##[0:2] o_calc_start) or
			($past(o_calc_start) || $past(o_calc_start, 2));
	endproperty
	a_ratio_stop: assert property (p_ratio_stop)
		else $error("ratio changed without a stop");
	property p_busy; o_calc_start |-> ##[0:1] o_calc_busy; endproperty
	a_busy: assert property (p_busy)
		else $error("calculation period not entered");
	property p_busy_len; $fell(o_calc_busy) |-> busy_len == 10'h1f4; endproperty
	a_busy_len: assert property (p_busy_len)
		else $error("calculation period has wrong length");
	property p_valid;
		$rose(o_ratio_valid) |-> $past(o_calc_busy) || $past(o_calc_busy, 2);
	endproperty
	a_valid: assert property (p_valid)
		else $error("result valid without a finished period");
	property p_crystal_buffer_out; o_crystal_buffer_out_sel == XT_TAB[{code_d, 1'b0} +: 2]; endproperty
	a_crystal_buffer_out: assert property (p_crystal_buffer_out)
		else $error("buffer source does not match test code");
	property p_pump;
		o_pump_mode == PM_TAB[{code_d, 1'b0} +: 2] &&
			o_tuning_volt_en == (code_d != 3'h6);
	endproperty
	a_pump: assert property (p_pump)
		else $error("pump mode does not match test code");
	property p_auto;
		o_auto_loop_bandwidth && $past(o_auto_loop_bandwidth) &&
			$stable(i_auto_ports) && $stable(i_auto_pump_sel) |->
			o_port_drive[2:0] == i_auto_ports &&
			o_pump_current_sel == i_auto_pump_sel;
	endproperty
	a_auto: assert property (p_auto)
		else $error("auto bandwidth not followed");
	property p_band;
		o_band_sel == {o_port_drive[1:0] == 2'h0, o_port_drive[1:0]};
	endproperty
	a_band: assert property (p_band)
		else $error("band select does not match ports");

	c_calc: cover property (o_calc_start);
	c_valid: cover property ($rose(o_ratio_valid));
	c_auto: cover property ($rose(o_auto_loop_bandwidth));
	c_ack: cover property ($fell(o_sda_oe_n));
endmodule // tsiwp_checker

bind tsiwp_top tsiwp_checker i_tsiwp_checker (.*);

// ### tb/tsiwp_bus_ctrl.sv
// tsiwp_bus_ctrl: behavioural two-wire bus controller for the bench.
// assumes pulled-up open-drain lines; the device only ever pulls low.
`timescale 1ns/1ps
module tsiwp_bus_ctrl (
	input wire logic i_mclk, // bench clock
	input wire logic i_sda_oe_n, // device data enable, low drives
	input wire logic i_sda_out, // device data drive value
	output logic o_scl, // bus clock line
	output logic o_sda // resolved data line
);
	logic sda_drv = 1'b1;
	logic got;

	// wired-and with pull-up: a released line floats back high
	assign o_sda = sda_drv & (i_sda_oe_n | i_sda_out);
	initial o_scl = 1'b1; // gated bus: clock idles between frames

	task automatic wt(input int n);
		repeat (n) @(posedge i_mclk);
	endtask

	// data falls while the clock is high; only called from idle
	task automatic start();
		sda_drv <= 1'b0;
		wt(6);
	endtask

	// low phase of 6 cycles leaves the device room to set up its ack
	task automatic pulse(input logic v);
		o_scl <= 1'b0;
		wt(3);
		sda_drv <= v;
		wt(3);
		o_scl <= 1'b1;
		wt(3);
		got = o_sda;
		wt(3);
	endtask

	// eight bits, most significant first, then a released ack slot
	task automatic send(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			pulse(b[i]);
		end
		pulse(1'b1);
		ack = !got;
	endtask

	// data rises while the clock is high; the clock then stands still
	task automatic stop();
		o_scl <= 1'b0;
		wt(3);
		sda_drv <= 1'b0;
		wt(3);
		o_scl <= 1'b1;
		wt(6);
		sda_drv <= 1'b1;
		wt(6);
	endtask
endmodule // tsiwp_bus_ctrl

// ### tb/tsiwp_top_test.sv
// tsiwp_top_test: scenario bench for the serial programming port.
// assumes the bus controller model and the bound checker beside it.
`timescale 1ns/1ps
module tsiwp_top_test;
	logic i_mclk, i_reset, i_ce, i_scl, i_sda, o_sda_out, o_sda_oe_n;
	logic o_calc_start, o_calc_busy, o_ratio_valid, o_gain_time_const;
	logic o_tuning_volt_en, o_auto_loop_bandwidth;
	logic [1:0] i_addr_strap_pin, o_crystal_buffer_out_sel, o_pump_mode;
	logic [2:0] i_auto_ports, i_auto_pump_sel, o_ref_ratio_sel, o_band_sel;
	logic [2:0] o_test_code, o_takeover_level, o_pump_current_sel;
	logic [4:0] o_port_drive;
	logic [14:0] o_ratio;
	int mismatches = 0;
	int tests_run = 0;

	// design and the bus controller that faces it
	tsiwp_top i_tsiwp_top (.*);
	tsiwp_bus_ctrl i_tsiwp_bus_ctrl (.i_mclk(i_mclk), .i_sda_oe_n(o_sda_oe_n),
		.i_sda_out(o_sda_out), .o_scl(i_scl), .o_sda(i_sda));

	// 10 MHz system clock
	initial begin
		i_mclk = 1'b0;
		forever #50 i_mclk = ~i_mclk;
	end

	// automatic: the watchdog and the main sequence wait at the same time
	task automatic wt(input int n);
		repeat (n) @(posedge i_mclk);
	endtask

	task chk(input logic [14:0] seen, input logic [14:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	task close_out();
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task put(input logic [7:0] b, input logic ack);
		logic a;
		i_tsiwp_bus_ctrl.send(b, a);
		chk(15'(a), 15'(ack));
	endtask

	task open(input logic [1:0] strap, input logic rw, input logic ack);
		i_tsiwp_bus_ctrl.start();
		put({tsiwp_pkg::ADDR_FIXED, strap, rw}, ack);
	endtask

	// stop, then keep off the bus until the calculation is done
	task fin();
		i_tsiwp_bus_ctrl.stop();
		wt(520);
	endtask

	task xfer1(input logic [7:0] b);
		open(i_addr_strap_pin, 1'b0, 1'b1);
		put(b, 1'b1);
		fin();
	endtask

	task t_reset_state();
		chk(o_ratio, 15'h0000);
		chk(15'(o_test_code), 15'h0006);
		chk(15'(o_crystal_buffer_out_sel), 15'h0001);
		chk(15'(o_tuning_volt_en), 15'h0000);
		chk(15'(o_port_drive), 15'h0000);
		chk(15'(o_band_sel), 15'h0004);
		chk(15'(o_auto_loop_bandwidth), 15'h0000);
	endtask

	// all five bytes in one transfer, index walking on its own
	task t_full_load();
		open(i_addr_strap_pin, 1'b0, 1'b1);
		put(8'h12, 1'b1);
		put(8'h34, 1'b1);
		put(8'hcb, 1'b1);
		put(8'ha5, 1'b1);
		chk(o_ratio, 15'h0000);
		fin();
		chk(o_ratio, 15'h1234);
		chk(15'(o_ref_ratio_sel), 15'h0003);
		chk(15'(o_test_code), 15'h0001);
		chk(15'(o_pump_current_sel), 15'h0005);
		chk(15'(o_port_drive), 15'h0005);
		chk(15'(o_band_sel), 15'h0001);
		chk(15'(o_ratio_valid), 15'h0001);
	endtask

	// control bytes act at once; surplus bytes are acked and dropped
	task t_partial();
		open(i_addr_strap_pin, 1'b0, 1'b1);
		put(8'h8d, 1'b1);
		chk(15'(o_gain_time_const), 15'h0001);
		chk(15'(o_takeover_level), 15'h0005);
		put(8'h00, 1'b1);
		put(8'hff, 1'b1);
		chk(15'(o_port_drive), 15'h0000);
		chk(15'(o_band_sel), 15'h0004);
		fin();
		xfer1(8'h85);
		chk(15'(o_gain_time_const), 15'h0000);
		xfer1(8'h05);
		chk(o_ratio, 15'h1234);
	endtask

	// foreign address and read direction leave everything alone
	task t_refused();
		open(~i_addr_strap_pin, 1'b0, 1'b0);
		put(8'hf8, 1'b0);
		i_tsiwp_bus_ctrl.stop();
		open(i_addr_strap_pin, 1'b1, 1'b0);
		fin();
		chk(15'(o_test_code), 15'h0001);
	endtask

	// with the clock enable low the port neither answers nor stores
	task t_frozen();
		i_ce <= 1'b0;
		open(i_addr_strap_pin, 1'b0, 1'b0);
		put(8'h8f, 1'b0);
		i_tsiwp_bus_ctrl.stop();
		i_ce <= 1'b1;
		wt(4);
		chk(15'(o_takeover_level), 15'h0005);
		chk(15'(o_gain_time_const), 15'h0000);
	endtask

	// every test code in turn; code 3 switches auto bandwidth on
	task t_test_codes();
		for (int c = 0; c < 8; c++) begin
			xfer1({2'b11, 3'(c), 3'h3});
			chk(15'(o_test_code), 15'(c));
			chk(15'(o_auto_loop_bandwidth), 15'(c >= 3));
		end
		i_auto_ports <= 3'h2;
		i_auto_pump_sel <= 3'h6;
		wt(4);
		chk(15'(o_port_drive[2:0]), 15'h0002);
		chk(15'(o_pump_current_sel), 15'h0006);
		xfer1(8'hdb);
		xfer1(8'hcb);
		chk(15'(o_auto_loop_bandwidth), 15'h0000);
		chk(15'(o_test_code), 15'h0001);
	endtask

	// a start inside the calculation period spoils the result
	task t_spoiled();
		open(i_addr_strap_pin, 1'b0, 1'b1);
		put(8'h2a, 1'b1);
		put(8'h55, 1'b1);
		i_tsiwp_bus_ctrl.stop();
		wt(10);
		open(~i_addr_strap_pin, 1'b0, 1'b0);
		i_tsiwp_bus_ctrl.stop();
		wt(520);
		chk(o_ratio, 15'h2a55);
		chk(15'(o_ratio_valid), 15'h0000);
	endtask

	// main sequence
	initial begin
		i_reset = 1'b1;
		i_ce = 1'b1;
		i_addr_strap_pin = 2'h2;
		i_auto_ports = 3'h0;
		i_auto_pump_sel = 3'h0;
		wt(20);
		i_reset <= 1'b0;
		wt(4);
		t_reset_state();
		t_full_load();
		t_partial();
		t_refused();
		t_frozen();
		t_test_codes();
		t_spoiled();
		close_out();
	end

	// watchdog, well beyond the roughly 13400 cycles the run needs
	initial begin
		wt(40000);
		mismatches++;
		close_out();
	end
endmodule // tsiwp_top_test
